/* File: logic/eeprom_slave.sv */
// Two-wire EEPROM slave front end: addressing, acknowledge, write cycle
`timescale 1ns/1ps
// Functional notes
// - Stop after write starts program, 6 ms
// - Busy: bus ignored, SDA released, no ack
// - Two array address bytes follow slave address
// - Master opens with START, closes with STOP
// - Receiver acks each byte, withholds to end
// - Slave address: type, select, direction bits
// - Addressed only when type field matches
// - Select bits must equal chip-select pins
// - Select bits also choose the block
// - Address LSB one reads, zero writes
// - Receiver pulls SDA low on ninth clock
// - First address byte high, second low
// - Master sends type, select, direction, addresses
// - Only six low high-address bits decode
// - START and STOP: SDA edge, SCL high
// - Write protect: no data ack, no program
// - Write data wraps within 64-byte page
module eeprom_slave #(
  parameter int unsigned WR_CYCLES = eeprom_pkg::WR_TIME_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  eeprom_link_if.device link,
  input wire logic chip_select_bit2,
  input wire logic chip_select_bit1,
  input wire logic chip_select_bit0,
  input wire logic write_protect,
  input wire logic [7:0] rd_data,
  output logic [eeprom_pkg::ADDR_W-1:0] mem_addr,
  output logic [eeprom_pkg::SEL_W-1:0] block_sel,
  output logic wr_en,
  output logic [7:0] wr_data,
  output logic prog_start,
  output logic busy
);
  import eeprom_pkg::*;

  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_RX = 3'h1,
    S_ACK = 3'h2,
    S_TX = 3'h3,
    S_MACK = 3'h4,
    S_IGN = 3'h5,
    S_BUSY = 3'h6
  } slave_st_e;

  typedef struct packed {
    slave_st_e st;
    logic [3:0] bcnt;
    logic [7:0] sh;
    logic [2:0] idx;
    logic rw;
    logic ackd;
    logic wrote;
    logic [ADDR_W-1:0] addr;
    logic [SEL_W-1:0] blk;
    logic [WR_CNT_W-1:0] cnt;
    logic sda_oe;
    logic wr_en;
    logic [7:0] wr_data;
    logic prog;
    logic busy;
    logic scl_q;
    logic sda_q;
  } slave_s;

  localparam logic [WR_CNT_W-1:0] WR_LAST = WR_CNT_W'(WR_CYCLES - 1);

  slave_s state_ff;
  slave_s nxt_state;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic [SEL_W-1:0] pins;
  logic type_ok;
  logic sel_ok;

  assign scl_rise = link.scl & ~state_ff.scl_q;
  assign scl_fall = ~link.scl & state_ff.scl_q;
  assign start_seen = link.scl & state_ff.scl_q & state_ff.sda_q & ~link.sda;
  assign stop_seen = link.scl & state_ff.scl_q & ~state_ff.sda_q & link.sda;
  assign pins = {chip_select_bit2, chip_select_bit1, chip_select_bit0};
  assign type_ok = state_ff.sh[SA_TYPE_MSB:SA_TYPE_LSB] == DEV_TYPE_ID;
  assign sel_ok = state_ff.sh[SA_SEL_MSB:SA_SEL_LSB] == pins;

  always_comb begin
    nxt_state = state_ff;
    nxt_state.scl_q = link.scl;
    nxt_state.sda_q = link.sda;
    nxt_state.wr_en = 1'b0;
    nxt_state.prog = 1'b0;
    if (state_ff.st == S_BUSY) begin
      // Bus edges are not looked at until the cycle ends
      nxt_state.sda_oe = 1'b0;
      if (state_ff.cnt == '0) begin
        nxt_state.st = S_IDLE;
      end else begin
        nxt_state.cnt = state_ff.cnt - 1'b1;
      end
    end else if (start_seen) begin
      // A START resynchronises from any state except S_BUSY, also after a mismatch
      nxt_state.st = S_RX;
      nxt_state.idx = IDX_SLAVE;
      nxt_state.bcnt = '0;
      nxt_state.sda_oe = 1'b0;
      nxt_state.wrote = 1'b0;
    end else if (stop_seen) begin
      nxt_state.sda_oe = 1'b0;
      if (state_ff.wrote && !write_protect) begin
        nxt_state.st = S_BUSY;
        nxt_state.cnt = WR_LAST;
        nxt_state.prog = 1'b1;
      end else begin
        nxt_state.st = S_IDLE;
      end
      nxt_state.wrote = 1'b0;
    end else begin
      case (state_ff.st)
        S_RX: begin
          if (scl_rise) begin
            nxt_state.sh = {state_ff.sh[6:0], link.sda};
            nxt_state.bcnt = state_ff.bcnt + 1'b1;
          end else if (scl_fall && state_ff.bcnt == BITS_PER_BYTE) begin
            nxt_state.st = S_ACK;
            nxt_state.ackd = 1'b1;
            case (state_ff.idx)
              IDX_SLAVE: begin
                // Both fields must match before anything is driven
                nxt_state.ackd = type_ok & sel_ok;
                nxt_state.rw = state_ff.sh[SA_RW_BIT] == RW_READ;
                if (type_ok & sel_ok) begin
                  nxt_state.blk = state_ff.sh[SA_SEL_MSB:SA_SEL_LSB];
                end
              end
              IDX_ADDR_HI: begin
                // Upper two bits of the byte are don't-care
                nxt_state.addr[ADDR_W-1:8] = state_ff.sh[HI_ADDR_BITS-1:0];
              end
              IDX_ADDR_LO: begin
                nxt_state.addr[7:0] = state_ff.sh;
              end
              default: begin
                if (write_protect) begin
                  nxt_state.ackd = 1'b0;
                end else begin
                  nxt_state.wr_en = 1'b1;
                  nxt_state.wr_data = state_ff.sh;
                  nxt_state.wrote = 1'b1;
                end
              end
            endcase
            // Ack goes out during the low phase before the ninth clock
            nxt_state.sda_oe = nxt_state.ackd;
          end
        end
        S_ACK: begin
          if (scl_fall) begin
            nxt_state.sda_oe = 1'b0;
            nxt_state.bcnt = '0;
            if (!state_ff.ackd) begin
              nxt_state.st = S_IGN;
            end else if (state_ff.idx == IDX_SLAVE && state_ff.rw) begin
              nxt_state.st = S_TX;
              nxt_state.sh = rd_data;
              nxt_state.sda_oe = ~rd_data[7];
            end else begin
              nxt_state.st = S_RX;
              if (state_ff.idx == IDX_DATA) begin
                // Wrap inside the page instead of crossing it
                nxt_state.addr[PAGE_BITS-1:0] =
                  state_ff.addr[PAGE_BITS-1:0] + 1'b1;
              end else begin
                nxt_state.idx = state_ff.idx + 1'b1;
              end
            end
          end
        end
        S_TX: begin
          if (scl_fall) begin
            nxt_state.bcnt = state_ff.bcnt + 1'b1;
            if (state_ff.bcnt[2:0] == LAST_TX_BIT) begin
              nxt_state.sda_oe = 1'b0;
              nxt_state.st = S_MACK;
            end else begin
              nxt_state.sh = {state_ff.sh[6:0], 1'b0};
              nxt_state.sda_oe = ~state_ff.sh[6];
            end
          end
        end
        S_MACK: begin
          if (scl_rise) begin
            // A missing master ack ends the read
            nxt_state.ackd = ~link.sda;
            if (!link.sda) begin
              nxt_state.addr = state_ff.addr + 1'b1;
            end
          end else if (scl_fall) begin
            nxt_state.bcnt = '0;
            if (state_ff.ackd) begin
              nxt_state.st = S_TX;
              nxt_state.sh = rd_data;
              nxt_state.sda_oe = ~rd_data[7];
            end else begin
              nxt_state.st = S_IGN;
            end
          end
        end
        S_IDLE, S_IGN: begin
          nxt_state.sda_oe = 1'b0;
        end
        default: begin
          nxt_state.st = S_IDLE;
          nxt_state.sda_oe = 1'b0;
        end
      endcase
    end
    nxt_state.busy = nxt_state.st == S_BUSY;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_ff <= '0;
      // Idle bus levels, so no false edge follows reset
      state_ff.scl_q <= 1'b1;
      state_ff.sda_q <= 1'b1;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign link.dev_sda_o = 1'b0;
  assign link.dev_sda_oe = state_ff.sda_oe;
  assign mem_addr = state_ff.addr;
  assign block_sel = state_ff.blk;
  assign wr_en = state_ff.wr_en;
  assign wr_data = state_ff.wr_data;
  assign prog_start = state_ff.prog;
  assign busy = state_ff.busy;
endmodule : eeprom_slave

/* File: logic/eeprom_pkg.sv */
// Shared constants for the two-wire EEPROM slave and its bus master
package eeprom_pkg;
  // Arbitrary memory-class identifier, not taken from any part
  localparam logic [3:0] DEV_TYPE_ID = 4'h5;
  localparam int SA_TYPE_MSB = 7;
  localparam int SA_TYPE_LSB = 4;
  localparam int SA_SEL_MSB = 3;
  localparam int SA_SEL_LSB = 1;
  localparam int SA_RW_BIT = 0;
  localparam logic RW_READ = 1'h1;
  localparam logic RW_WRITE = 1'h0;
  localparam int ADDR_W = 14;
  localparam int HI_ADDR_BITS = 6;
  localparam int PAGE_BITS = 6;
  localparam int SEL_W = 3;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [2:0] LAST_TX_BIT = 3'h7;
  localparam int CLK_HZ = 10_000_000;
  localparam int WR_TIME_MS = 6;
  // Longest time, rounded down to whole cycles
  localparam int WR_TIME_CYC = (CLK_HZ / 1000) * WR_TIME_MS;
  localparam int WR_CNT_W = 17;
  localparam int SCL_HZ = 50_000;
  localparam int SCL_QTR_CYC = CLK_HZ / (4 * SCL_HZ);
  localparam int QTR_W = 6;
  localparam logic [2:0] IDX_SLAVE = 3'h0;
  localparam logic [2:0] IDX_ADDR_HI = 3'h1;
  localparam logic [2:0] IDX_ADDR_LO = 3'h2;
  localparam logic [2:0] IDX_DATA = 3'h3;
  localparam logic [2:0] IDX_RDATA = 3'h4;
endpackage : eeprom_pkg

/* File: logic/eeprom_link_if.sv */
// Two-wire link between the bus master and the EEPROM slave
`timescale 1ns/1ps
interface eeprom_link_if;
  logic scl;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic sda;

  // Open drain with pull-up: any enabled low driver wins
  assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

  modport device(input scl, input sda, output dev_sda_o, output dev_sda_oe);
  modport host(output scl, output host_sda_o, output host_sda_oe, input sda);
endinterface : eeprom_link_if

/* File: logic/eeprom_master.sv */
// Two-wire bus master: single-byte write and random single-byte read
`timescale 1ns/1ps
module eeprom_master (
  input wire logic clk,
  input wire logic sys_rst,
  eeprom_link_if.host link,
  input wire logic cmd_valid,
  input wire logic cmd_read,
  input wire logic [eeprom_pkg::SEL_W-1:0] cmd_sel,
  input wire logic [eeprom_pkg::ADDR_W-1:0] cmd_addr,
  input wire logic [7:0] cmd_wdata,
  output logic cmd_ready,
  output logic done,
  output logic nack_err,
  output logic [7:0] rd_byte
);
  import eeprom_pkg::*;

  typedef enum logic [1:0] {
    H_IDLE = 2'h0,
    H_START = 2'h1,
    H_BIT = 2'h2,
    H_STOP = 2'h3
  } host_st_e;

  typedef struct packed {
    host_st_e st;
    logic [1:0] q;
    logic [QTR_W-1:0] cnt;
    logic [3:0] bitn;
    logic [2:0] idx;
    logic [7:0] sh;
    logic rd;
    logic [SEL_W-1:0] sel;
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic scl;
    logic sda_oe;
    logic ready;
    logic done;
    logic err;
    logic [7:0] rdata;
  } host_s;

  localparam logic [QTR_W-1:0] QTR_LAST = QTR_W'(SCL_QTR_CYC - 1);

  host_s state_ff;
  host_s nxt_state;
  logic tick;
  logic [7:0] byte_out;
  logic rx_byte;

  assign tick = state_ff.cnt == QTR_LAST;
  assign rx_byte = state_ff.idx == IDX_RDATA;

  // Byte order of one transfer
  always_comb begin
    case (state_ff.idx)
      IDX_SLAVE: byte_out = {DEV_TYPE_ID, state_ff.sel, RW_WRITE};
      IDX_ADDR_HI: byte_out = {2'h0, state_ff.addr[ADDR_W-1:8]};
      IDX_ADDR_LO: byte_out = state_ff.addr[7:0];
      IDX_DATA: byte_out = state_ff.rd ? {DEV_TYPE_ID, state_ff.sel, RW_READ} : state_ff.wdata;
      default: byte_out = 8'hFF;
    endcase
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_state.done = 1'b0;
    nxt_state.cnt = tick ? '0 : state_ff.cnt + 1'b1;
    if (tick && state_ff.st != H_IDLE) begin
      nxt_state.q = state_ff.q + 1'b1;
    end
    case (state_ff.st)
      H_IDLE: begin
        nxt_state.cnt = '0;
        nxt_state.q = '0;
        nxt_state.ready = 1'b1;
        if (cmd_valid) begin
          nxt_state.ready = 1'b0;
          nxt_state.err = 1'b0;
          nxt_state.rd = cmd_read;
          nxt_state.sel = cmd_sel;
          nxt_state.addr = cmd_addr;
          nxt_state.wdata = cmd_wdata;
          nxt_state.idx = IDX_SLAVE;
          nxt_state.st = H_START;
        end
      end
      H_START: begin
        if (tick) begin
          // Low first, so a repeated START sees no false STOP
          case (state_ff.q)
            2'h0: nxt_state.scl = 1'b0;
            2'h1: nxt_state.sda_oe = 1'b0;
            2'h2: nxt_state.scl = 1'b1;
            default: begin
              nxt_state.sda_oe = 1'b1;
              nxt_state.st = H_BIT;
              nxt_state.bitn = '0;
              nxt_state.sh = byte_out;
            end
          endcase
        end
      end
      H_BIT: begin
        if (tick) begin
          case (state_ff.q)
            2'h0: nxt_state.scl = 1'b0;
            2'h1: begin
              // Only one byte is read, so the ninth bit is always a nack
              if (state_ff.bitn < BITS_PER_BYTE && !rx_byte) begin
                nxt_state.sda_oe = ~state_ff.sh[7];
              end else begin
                nxt_state.sda_oe = 1'b0;
              end
            end
            2'h2: nxt_state.scl = 1'b1;
            default: begin
              nxt_state.bitn = state_ff.bitn + 1'b1;
              if (state_ff.bitn < BITS_PER_BYTE) begin
                nxt_state.sh = {state_ff.sh[6:0], rx_byte ? link.sda : 1'b0};
              end else if (!rx_byte && link.sda) begin
                nxt_state.err = 1'b1;
                nxt_state.st = H_STOP;
              end else if (rx_byte) begin
                nxt_state.rdata = state_ff.sh;
                nxt_state.st = H_STOP;
              end else if (state_ff.idx == IDX_DATA && !state_ff.rd) begin
                nxt_state.st = H_STOP;
              end else if (state_ff.idx == IDX_ADDR_LO && state_ff.rd) begin
                nxt_state.idx = IDX_DATA;
                nxt_state.st = H_START;
              end else begin
                nxt_state.idx = state_ff.idx + 1'b1;
                nxt_state.bitn = '0;
                nxt_state.sh = state_ff.idx == IDX_DATA ? 8'hFF : byte_out_next(state_ff);
              end
            end
          endcase
        end
      end
      default: begin
        if (tick) begin
          case (state_ff.q)
            2'h0: nxt_state.scl = 1'b0;
            2'h1: nxt_state.sda_oe = 1'b1;
            2'h2: nxt_state.scl = 1'b1;
            default: begin
              nxt_state.sda_oe = 1'b0;
              nxt_state.done = 1'b1;
              nxt_state.ready = 1'b1;
              nxt_state.st = H_IDLE;
            end
          endcase
        end
      end
    endcase
  end

  function automatic logic [7:0] byte_out_next(input host_s s);
    logic [7:0] b;
    b = 8'h00;
    case (s.idx)
      IDX_SLAVE: b = {2'h0, s.addr[ADDR_W-1:8]};
      IDX_ADDR_HI: b = s.addr[7:0];
      default: b = s.rd ? {DEV_TYPE_ID, s.sel, RW_READ} : s.wdata;
    endcase
    return b;
  endfunction : byte_out_next

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_ff <= '0;
      state_ff.scl <= 1'b1;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign link.scl = state_ff.scl;
  assign link.host_sda_o = 1'b0;
  assign link.host_sda_oe = state_ff.sda_oe;
  assign cmd_ready = state_ff.ready;
  assign done = state_ff.done;
  assign nack_err = state_ff.err;
  assign rd_byte = state_ff.rdata;
endmodule : eeprom_master

/* File: dv/eeprom_link_assertions.sv */
// Concurrent checks on the two-wire link and slave status
`timescale 1ns/1ps
module eeprom_link_assertions #(
  parameter int unsigned WR_CYCLES = 60000
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic scl,
  input wire logic sda,
  input wire logic host_sda_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic write_protect,
  input wire logic wr_en,
  input wire logic prog_start,
  input wire logic busy
);
  logic [31:0] busy_cnt_ff;
  logic [31:0] nxt_busy_cnt;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // Counter instead of a long repetition
  always_comb begin
    nxt_busy_cnt = busy ? busy_cnt_ff + 32'h1 : 32'h0;
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      busy_cnt_ff <= 32'h0;
    end else begin
      busy_cnt_ff <= nxt_busy_cnt;
    end
  end
  property p_ack_low;
    dev_sda_oe |-> !dev_sda_o && !sda;
  endproperty
  a_ack_low: assert property (p_ack_low) else $error("device drive not low on wire");
  property p_dev_scl_low;
    $changed(dev_sda_oe) |-> !scl;
  endproperty
  a_dev_scl_low: assert property (p_dev_scl_low) else $error("device sda moved, scl high");
  property p_ack_hold;
    $rose(dev_sda_oe) |-> dev_sda_oe throughout (##[1:300] $fell(scl));
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("device drive cut short");
  property p_busy_silent;
    busy |-> !dev_sda_oe;
  endproperty
  a_busy_silent: assert property (p_busy_silent) else $error("sda driven while busy");
  property p_prog_busy;
    prog_start |=> busy;
  endproperty
  a_prog_busy: assert property (p_prog_busy) else $error("no busy after program start");
  property p_busy_bound;
    busy |-> busy_cnt_ff <= WR_CYCLES;
  endproperty
  a_busy_bound: assert property (p_busy_bound) else $error("write cycle too long");
  property p_wr_acked;
    wr_en |-> dev_sda_oe && !scl;
  endproperty
  a_wr_acked: assert property (p_wr_acked) else $error("data byte stored without ack");
  property p_wp_no_prog;
    write_protect |-> !wr_en && !prog_start;
  endproperty
  a_wp_no_prog: assert property (p_wp_no_prog) else $error("write under protect");
  c_prog: cover property (prog_start);
  c_wr: cover property (wr_en);
  c_busy_traffic: cover property (busy && host_sda_oe);
endmodule : eeprom_link_assertions

/* File: dv/eeprom_two_wire_slave_addressing_tb.sv */
// Self-checking bench joining the two-wire master and the slave
`timescale 1ns/1ps
module eeprom_two_wire_slave_addressing_tb;
  import eeprom_pkg::*;
  localparam int unsigned WR_CYC = 4000;
  logic clk;
  logic sys_rst;
  logic [2:0] cs;
  logic write_protect;
  logic [7:0] rd_data = 8'h00;
  logic [ADDR_W-1:0] mem_addr;
  logic [SEL_W-1:0] block_sel;
  logic wr_en;
  logic [7:0] wr_data;
  logic prog_start;
  logic busy;
  logic cmd_valid;
  logic cmd_read;
  logic [SEL_W-1:0] cmd_sel;
  logic [ADDR_W-1:0] cmd_addr;
  logic [7:0] cmd_wdata;
  logic cmd_ready;
  logic done;
  logic nack_err;
  logic [7:0] rd_byte;
  logic [7:0] mem [0:131071];
  logic [31:0] rng;
  logic [16:0] last_loc = 17'h00000;
  logic [7:0] last_data = 8'h00;
  int bad_count;
  int cmp_count;
  int wr_cnt = 0;
  eeprom_link_if u_eeprom_link_if ();
  eeprom_slave #(.WR_CYCLES(WR_CYC)) u_eeprom_slave (
    .clk(clk), .sys_rst(sys_rst), .link(u_eeprom_link_if), .chip_select_bit2(cs[2]),
    .chip_select_bit1(cs[1]), .chip_select_bit0(cs[0]), .write_protect(write_protect),
    .rd_data(rd_data), .mem_addr(mem_addr), .block_sel(block_sel), .wr_en(wr_en),
    .wr_data(wr_data), .prog_start(prog_start), .busy(busy));
  eeprom_master u_eeprom_master (
    .clk(clk), .sys_rst(sys_rst), .link(u_eeprom_link_if), .cmd_valid(cmd_valid),
    .cmd_read(cmd_read), .cmd_sel(cmd_sel), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .cmd_ready(cmd_ready), .done(done), .nack_err(nack_err), .rd_byte(rd_byte));
  eeprom_link_assertions #(.WR_CYCLES(WR_CYC)) u_eeprom_link_assertions (
    .clk(clk), .sys_rst(sys_rst), .scl(u_eeprom_link_if.scl), .sda(u_eeprom_link_if.sda),
    .host_sda_oe(u_eeprom_link_if.host_sda_oe), .dev_sda_o(u_eeprom_link_if.dev_sda_o),
    .dev_sda_oe(u_eeprom_link_if.dev_sda_oe), .write_protect(write_protect), .wr_en(wr_en),
    .prog_start(prog_start), .busy(busy));
  // Array model keyed by block and address
  always @(posedge clk) begin
    rd_data <= mem[{block_sel, mem_addr}];
    if (wr_en === 1'b1) begin
      mem[{block_sel, mem_addr}] <= wr_data;
      wr_cnt <= wr_cnt + 1;
      last_loc <= {block_sel, mem_addr};
      last_data <= wr_data;
    end
  end
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  function automatic logic [31:0] next_rand();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction : next_rand
  function automatic logic exp_fail(input logic [2:0] s, input logic [2:0] p, input logic w,
                                    input logic b);
    return (s !== p) || w || b;
  endfunction : exp_fail
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      bad_count++;
    end
  endtask : chk
  task automatic timed_out();
    $display("MISMATCH timeout expected handshake seen none");
    bad_count++;
    give_verdict();
  endtask : timed_out
  task automatic do_cmd(input logic r, input logic [2:0] s, input logic [13:0] a,
                        input logic [7:0] d);
    int n;
    n = 0;
    @(negedge clk);
    while (cmd_ready !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    if (cmd_ready !== 1'b1) timed_out();
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_read <= r;
    cmd_sel <= s;
    cmd_addr <= a;
    cmd_wdata <= d;
    @(posedge clk);
    cmd_valid <= 1'b0;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (done !== 1'b1 && n < 12000);
    if (done !== 1'b1) timed_out();
  endtask : do_cmd
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 10000) begin
      @(negedge clk);
      n++;
    end
    if (busy !== 1'b0) timed_out();
  endtask : wait_idle
  task automatic set_pins(input logic [2:0] p, input logic w);
    @(posedge clk);
    cs <= p;
    write_protect <= w;
    @(posedge clk);
  endtask : set_pins
  task automatic run_write(input logic [2:0] s, input logic [13:0] a, input logic [7:0] d);
    int w0;
    int n;
    logic f;
    logic b;
    w0 = wr_cnt;
    b = busy === 1'b1;
    f = exp_fail(s, cs, write_protect, b);
    do_cmd(1'b0, s, a, d);
    chk("write nack", {31'h0, f}, {31'h0, nack_err});
    chk("write count", w0 + (f ? 0 : 1), wr_cnt);
    if (!f) begin
      chk("write location", {15'h0, s, a}, {15'h0, last_loc});
      chk("write data", {24'h0, d}, {24'h0, last_data});
      // Address after the byte stays inside its page
      chk("page wrap", {18'h0, a[13:6], a[5:0] + 6'h01}, {18'h0, mem_addr});
    end
    n = 0;
    while (!f && busy !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    // A refused write leaves a running cycle as it was
    chk("busy after stop", {31'h0, !f || b}, {31'h0, busy});
  endtask : run_write
  task automatic run_read(input logic [2:0] s, input logic [13:0] a, input logic [7:0] d);
    do_cmd(1'b1, s, a, 8'h00);
    chk("read nack", 32'h0, {31'h0, nack_err});
    chk("read byte", {24'h0, d}, {24'h0, rd_byte});
  endtask : run_read
  initial begin
    logic [2:0] s;
    logic [13:0] a;
    logic [7:0] d;
    logic [7:0] d0;
    sys_rst = 1'b1;
    cs = 3'h2;
    write_protect = 1'b0;
    cmd_valid = 1'b0;
    cmd_read = 1'b0;
    cmd_sel = 3'h0;
    cmd_addr = 14'h0000;
    cmd_wdata = 8'h00;
    rng = 32'h4608CE93;
    bad_count = 0;
    cmp_count = 0;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    // Top address on block 2 first, then a random one
    for (int i = 0; i < 2; i++) begin
      s = (i == 0) ? 3'h2 : 3'(next_rand());
      a = (i == 0) ? 14'h3FFF : 14'(next_rand());
      d = 8'(next_rand());
      if (i == 0) d0 = d;
      set_pins(s, 1'b0);
      run_write(s, a, d);
      wait_idle();
      run_read(s, a, d);
    end
    $display("test write_read finished");
    set_pins(3'h2, 1'b0);
    for (int i = 0; i < 3; i++) begin
      run_write(3'h2 ^ (3'h1 << i), 14'(next_rand()), 8'h3C);
    end
    $display("test select_mismatch finished");
    set_pins(3'h2, 1'b1);
    run_write(3'h2, 14'h3FFF, ~d0);
    set_pins(3'h2, 1'b0);
    run_read(3'h2, 14'h3FFF, d0);
    $display("test write_protect finished");
    // Second write lands while the first still programs
    run_write(3'h2, 14'h0000, 8'h5A);
    run_write(3'h2, 14'h0001, 8'hC3);
    wait_idle();
    run_read(3'h2, 14'h0000, 8'h5A);
    $display("test busy_write finished");
    give_verdict();
  end
endmodule : eeprom_two_wire_slave_addressing_tb
